// File: design/aer_pkg.sv
// Constants, layouts and bus types for the error report register bank.
// Assumes a 32-bit classic Wishbone slave on byte addresses.
package aer_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_UNC_STS = 8'h04;  // Uncorrectable status
  localparam logic [7:0] OFF_UNC_MSK = 8'h08;  // Uncorrectable mask
  localparam logic [7:0] OFF_UNC_SEV = 8'h0C;  // Uncorrectable severity
  localparam logic [7:0] OFF_COR_STS = 8'h10;  // Correctable status
  localparam logic [7:0] OFF_COR_MSK = 8'h14;  // Correctable mask
  localparam logic [7:0] OFF_CTL     = 8'h18;  // Capabilities and control
  localparam logic [7:0] OFF_IRQ_STS = 8'h50;  // Interrupt status
  localparam logic [7:0] OFF_IRQ_MSK = 8'h54;  // Interrupt mask

  // ==========================================================
  // Implemented bits and reset values
  localparam logic [31:0] UNC_IMPL    = 32'h005F_7010;  // Writable uncorr bits
  localparam logic [31:0] SEV_RST     = 32'h0046_2010;  // Severity reset
  localparam logic [31:0] UNC_MSK_RST = 32'h0040_0000;  // Uncorr mask reset
  localparam logic [31:0] COR_IMPL    = 32'h0000_71C1;  // Implemented corr bits
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;  // Cleared word

  // ==========================================================
  // Control register fields
  localparam int CTL_PLP  = 11;  // Prefix log present
  localparam int CTL_MHEN = 10;  // Multi header record enable
  localparam int CTL_MHCP = 9;   // Multi header record capable
  localparam int CTL_CCE  = 8;   // Crc check enable
  localparam int CTL_CCC  = 7;   // Crc check capable
  localparam int CTL_CGE  = 6;   // Crc generation enable
  localparam int CTL_CGC  = 5;   // Crc generation capable
  localparam int PTR_W    = 5;   // First error pointer width
  localparam logic [PTR_W-1:0] PTR_RST = 5'h00;  // Pointer reset

  // Capabilities of this build
  localparam logic MHR_CAPABLE     = 1'b0;  // No multi header logging
  localparam logic CRC_CHK_CAPABLE = 1'b1;  // Checker present
  localparam logic CRC_GEN_CAPABLE = 1'b1;  // Generator present

  // ==========================================================
  // Interrupt status layout
  localparam int IRQ_W   = 3;  // Number of events
  localparam int IRQ_COR = 0;  // Correctable reported
  localparam int IRQ_NF  = 1;  // Non-fatal reported
  localparam int IRQ_FAT = 2;  // Fatal reported
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;  // Interrupt regs reset

  // Wishbone request from the master
  typedef struct packed {
    logic        cyc;  // Cycle
    logic        stb;  // Strobe
    logic        we;   // Write enable
    logic [7:0]  adr;  // Byte address
    logic [3:0]  sel;  // Byte selects
    logic [31:0] dat;  // Write data
  } aer_wb_req_t;

endpackage

// File: design/aer_regs.sv
// Error report register bank with Wishbone slave and interrupt.
// Assumes error pulses come from logic on clk_i; rst_i is the cold reset,
// hot_rst_i and flr_i are the warm resets that sticky state ignores.
//
// Operation
// [R01] Severity one reports fatal, zero non-fatal
// [R02] Sticky fields ignore hot reset and FLR
// [R03] Severity resets one at 22,18,17,13,4
// [R04] Mandatory severity writable, unimplemented optional read-only
// [R05] Correctable sources flagged at fixed bit positions
// [R06] Correctable status resets zero, sets, write-one clears
// [R07] Masked correctable error is not reported
// [R08] Correctable mask aligned, resets zero, writable
// [R09] Prefix log present flag, read-only
// [R10] Multi header enable, zero when absent
// [R11] Multi header capable bit reports capability
// [R12] Crc check enable, reset zero
// [R13] Crc check capable read-only bit
// [R14] Crc generation enable, reset zero
// [R15] Crc generation capable read-only bit
// [R16] First error pointer, sticky, resets zero
// [R17] Masked uncorrectable error neither logged nor reported
// [R18] Uncorrectable status, write-one-to-clear flags
// [R19] Reserved bits read zero, zero writes no-op
module aer_regs
  import aer_pkg::*;
(
  input  wire logic               clk_i,          // 10 MHz clock
  input  wire logic               rst_i,          // Cold reset
  input  wire logic               hot_rst_i,      // Hot reset
  input  wire logic               flr_i,          // Function level reset
  input  wire aer_pkg::aer_wb_req_t wb_i,         // Wishbone request
  output logic [31:0]             wb_dat_o,       // Read data
  output logic                    wb_ack_o,       // Acknowledge
  input  wire logic [31:0]        unc_err_i,      // Uncorr error pulses
  input  wire logic [15:0]        cor_err_i,      // Corr error pulses
  input  wire logic               prefix_valid_i, // Prefix captured
  output logic                    err_fatal_o,    // Fatal report pulse
  output logic                    err_nonfatal_o, // Non-fatal pulse
  output logic                    err_cor_o,      // Correctable pulse
  output logic                    crc_chk_en_o,   // Crc check on
  output logic                    crc_gen_en_o,   // Crc generation on
  output logic                    multi_hdr_en_o, // Multi header on
  output logic                    irq_o           // Interrupt level
);

  // ==========================================================
  // Helper functions

  // Byte selects to bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] sel);
    be_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // Lowest set bit index
  function automatic logic [PTR_W-1:0] low_idx(input logic [31:0] v);
    low_idx = PTR_RST;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        low_idx = i[PTR_W-1:0];
      end
    end
  endfunction

  // ==========================================================
  // State
  logic [31:0]      unc_sts_q, unc_sts_d;  // Uncorr status
  logic [31:0]      unc_msk_q, unc_msk_d;  // Uncorr mask
  logic [31:0]      unc_sev_q, unc_sev_d;  // Severity
  logic [31:0]      cor_sts_q, cor_sts_d;  // Corr status
  logic [31:0]      cor_msk_q, cor_msk_d;  // Corr mask
  logic [PTR_W-1:0] ptr_q, ptr_d;          // First error pointer
  logic             plp_q, plp_d;          // Prefix log present
  logic             mhen_q, mhen_d;        // Multi header enable
  logic             cce_q, cce_d;          // Crc check enable
  logic             cge_q, cge_d;          // Crc generation enable
  logic [IRQ_W-1:0] irq_sts_q, irq_sts_d;  // Interrupt status
  logic [IRQ_W-1:0] irq_msk_q, irq_msk_d;  // Interrupt mask
  logic             ack_q, ack_d;          // Bus acknowledge
  logic [31:0]      dat_q, dat_d;          // Bus read data
  logic             fat_q, fat_d;          // Fatal pulse
  logic             nf_q, nf_d;            // Non-fatal pulse
  logic             cor_q, cor_d;          // Corr pulse
  logic             irq_q, irq_d;          // Interrupt level

  // Decoded bus and error terms
  logic        bus_req;   // New access this cycle
  logic        bus_wr;    // New write
  logic        bus_rd;    // New read
  logic [31:0] wmask;     // Write byte mask
  logic [31:0] wbits;     // Write ones within mask
  logic [31:0] unc_new;   // Detected uncorr errors
  logic [31:0] unc_rep;   // Unmasked uncorr errors
  logic [31:0] cor_new;   // Detected corr errors
  logic [31:0] cor_rep;   // Unmasked corr errors
  logic        ptr_free;  // Pointer free for a new error
  logic        warm;      // Hot reset or FLR
  logic [31:0] ctl_rd;    // Control register read view

  // ==========================================================
  // Decode of bus and error inputs
  always_comb begin
    bus_req  = wb_i.cyc & wb_i.stb & ~ack_q;
    bus_wr   = bus_req & wb_i.we;
    bus_rd   = bus_req & ~wb_i.we;
    wmask    = be_mask(wb_i.sel);
    wbits    = wb_i.dat & wmask;
    warm     = hot_rst_i | flr_i;
    unc_new  = unc_err_i & UNC_IMPL;
    unc_rep  = unc_new & ~unc_msk_q;                       // R17
    cor_new  = {16'h0000, cor_err_i} & COR_IMPL;           // R05
    cor_rep  = cor_new & ~cor_msk_q;                       // R07
    ptr_free = ~unc_sts_q[ptr_q];
    ctl_rd   = WORD_ZERO;                                  // R19
    ctl_rd[CTL_PLP]  = plp_q;                              // R09
    ctl_rd[CTL_MHEN] = mhen_q;                             // R10
    ctl_rd[CTL_MHCP] = MHR_CAPABLE;                        // R11
    ctl_rd[CTL_CCE]  = cce_q;                              // R12
    ctl_rd[CTL_CCC]  = CRC_CHK_CAPABLE;                    // R13
    ctl_rd[CTL_CGE]  = cge_q;                              // R14
    ctl_rd[CTL_CGC]  = CRC_GEN_CAPABLE;                    // R15
    ctl_rd[PTR_W-1:0] = ptr_q;                             // R16
  end

  // ==========================================================
  // Sticky error registers: next values
  always_comb begin
    unc_sts_d = unc_sts_q;
    unc_msk_d = unc_msk_q;
    unc_sev_d = unc_sev_q;
    cor_sts_d = cor_sts_q;
    cor_msk_d = cor_msk_q;
    ptr_d     = ptr_q;
    plp_d     = plp_q;
    mhen_d    = mhen_q;
    cce_d     = cce_q;
    cge_d     = cge_q;
    // Register writes
    if (bus_wr && wb_i.adr == OFF_UNC_STS) begin
      unc_sts_d = unc_sts_q & ~(wbits & UNC_IMPL);       // R18 R19
    end else if (bus_wr && wb_i.adr == OFF_UNC_MSK) begin
      unc_msk_d = (unc_msk_q & ~(wmask & UNC_IMPL))
                | (wbits & UNC_IMPL);
    end else if (bus_wr && wb_i.adr == OFF_UNC_SEV) begin
      unc_sev_d = (unc_sev_q & ~(wmask & UNC_IMPL))      // R04
                | (wbits & UNC_IMPL);
    end else if (bus_wr && wb_i.adr == OFF_COR_STS) begin
      cor_sts_d = cor_sts_q & ~(wbits & COR_IMPL);       // R06 R19
    end else if (bus_wr && wb_i.adr == OFF_COR_MSK) begin
      cor_msk_d = (cor_msk_q & ~(wmask & COR_IMPL))      // R08
                | (wbits & COR_IMPL);
    end else if (bus_wr && wb_i.adr == OFF_CTL) begin
      // Each enable follows the byte lane that carries it
      if (wmask[CTL_MHEN]) begin
        mhen_d = wb_i.dat[CTL_MHEN] & MHR_CAPABLE;       // R10
      end
      if (wmask[CTL_CCE]) begin
        cce_d = wb_i.dat[CTL_CCE] & CRC_CHK_CAPABLE;     // R12
      end
      if (wmask[CTL_CGE]) begin
        cge_d = wb_i.dat[CTL_CGE] & CRC_GEN_CAPABLE;     // R14
      end
    end
    // Detection sets status; a set wins over a clear
    unc_sts_d = unc_sts_d | unc_new;                     // R18
    cor_sts_d = cor_sts_d | cor_new;                     // R06
    // Capture the first unmasked error once the pointer is free
    if (ptr_free && unc_rep != WORD_ZERO) begin
      ptr_d = low_idx(unc_rep);                          // R16 R17
      plp_d = prefix_valid_i;                            // R09
    end
  end

  // Sticky registers: only the cold reset acts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin                                     // R02
      unc_sts_q <= WORD_ZERO;
      unc_msk_q <= UNC_MSK_RST;
      unc_sev_q <= SEV_RST;                              // R03
      cor_sts_q <= WORD_ZERO;                            // R06
      cor_msk_q <= WORD_ZERO;                            // R08
      ptr_q     <= PTR_RST;                              // R16
      plp_q     <= 1'b0;
      mhen_q    <= 1'b0;
      cce_q     <= 1'b0;
      cge_q     <= 1'b0;
    end else begin
      unc_sts_q <= unc_sts_d;
      unc_msk_q <= unc_msk_d;
      unc_sev_q <= unc_sev_d;
      cor_sts_q <= cor_sts_d;
      cor_msk_q <= cor_msk_d;
      ptr_q     <= ptr_d;
      plp_q     <= plp_d;
      mhen_q    <= mhen_d;
      cce_q     <= cce_d;
      cge_q     <= cge_d;
    end
  end

  // ==========================================================
  // Reporting, interrupt and bus answer: next values
  always_comb begin
    fat_d     = |(unc_rep & unc_sev_q);                  // R01
    nf_d      = |(unc_rep & ~unc_sev_q);                 // R01
    cor_d     = |cor_rep;                                // R07
    irq_sts_d = irq_sts_q;
    irq_msk_d = irq_msk_q;
    ack_d     = bus_req;
    dat_d     = WORD_ZERO;
    // Read mux; unmapped addresses read zero
    if (bus_rd && wb_i.adr == OFF_UNC_STS) begin
      dat_d = unc_sts_q;
    end else if (bus_rd && wb_i.adr == OFF_UNC_MSK) begin
      dat_d = unc_msk_q;
    end else if (bus_rd && wb_i.adr == OFF_UNC_SEV) begin
      dat_d = unc_sev_q;
    end else if (bus_rd && wb_i.adr == OFF_COR_STS) begin
      dat_d = cor_sts_q;
    end else if (bus_rd && wb_i.adr == OFF_COR_MSK) begin
      dat_d = cor_msk_q;
    end else if (bus_rd && wb_i.adr == OFF_CTL) begin
      dat_d = ctl_rd;
    end else if (bus_rd && wb_i.adr == OFF_IRQ_STS) begin
      dat_d[IRQ_W-1:0] = irq_sts_q;
      irq_sts_d        = IRQ_RST;                        // Read clears
    end else if (bus_rd && wb_i.adr == OFF_IRQ_MSK) begin
      dat_d[IRQ_W-1:0] = irq_msk_q;
    end else if (bus_wr && wb_i.adr == OFF_IRQ_MSK && wb_i.sel[0]) begin
      irq_msk_d = wb_i.dat[IRQ_W-1:0];
    end
    // Events set sticky bits, winning over the read clear
    irq_sts_d[IRQ_COR] = irq_sts_d[IRQ_COR] | cor_d;
    irq_sts_d[IRQ_NF]  = irq_sts_d[IRQ_NF] | nf_d;
    irq_sts_d[IRQ_FAT] = irq_sts_d[IRQ_FAT] | fat_d;
    // Warm reset clears the non-sticky interrupt state
    if (warm) begin
      irq_sts_d = IRQ_RST;
      irq_msk_d = IRQ_RST;
    end
    irq_d = |(irq_sts_d & irq_msk_d);
  end

  // Non-sticky registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fat_q     <= 1'b0;
      nf_q      <= 1'b0;
      cor_q     <= 1'b0;
      irq_sts_q <= IRQ_RST;
      irq_msk_q <= IRQ_RST;
      ack_q     <= 1'b0;
      dat_q     <= WORD_ZERO;
      irq_q     <= 1'b0;
    end else begin
      fat_q     <= fat_d;
      nf_q      <= nf_d;
      cor_q     <= cor_d;
      irq_sts_q <= irq_sts_d;
      irq_msk_q <= irq_msk_d;
      ack_q     <= ack_d;
      dat_q     <= dat_d;
      irq_q     <= irq_d;
    end
  end

  // ==========================================================
  // Outputs straight from flip-flops
  assign wb_dat_o       = dat_q;
  assign wb_ack_o       = ack_q;
  assign err_fatal_o    = fat_q;
  assign err_nonfatal_o = nf_q;
  assign err_cor_o      = cor_q;
  assign crc_chk_en_o   = cce_q;
  assign crc_gen_en_o   = cge_q;
  assign multi_hdr_en_o = mhen_q;
  assign irq_o          = irq_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Fatal and non-fatal split by severity
  sev_split_a: assert property (((unc_rep & unc_sev_q) != WORD_ZERO) |=> err_fatal_o) // R01
    else $error("fatal report missing");
  // Non-fatal report follows a clear severity bit
  sev_nf_a: assert property (((unc_rep & ~unc_sev_q) != WORD_ZERO) |=> err_nonfatal_o) // R01
    else $error("non-fatal report missing");
  // No report of a kind without an error of that kind
  fat_quiet_a: assert property (((unc_rep & unc_sev_q) == WORD_ZERO) |=> !err_fatal_o) // R01
    else $error("fatal report without error");
  nf_quiet_a: assert property (((unc_rep & ~unc_sev_q) == WORD_ZERO) |=> !err_nonfatal_o) // R01
    else $error("non-fatal report without error");
  // Warm reset leaves sticky fields alone
  sticky_keep_a: assert property ((warm && !bus_wr && unc_new == WORD_ZERO // R02
    && cor_new == WORD_ZERO) |=> $stable(unc_sev_q) && $stable(cor_sts_q)
    && $stable(cor_msk_q) && $stable(ptr_q) && $stable(cce_q) && $stable(cge_q))
    else $error("sticky field changed by warm reset");
  // Severity reset value
  sev_reset_a: assert property ($past(rst_i) |-> unc_sev_q == SEV_RST) // R03
    else $error("severity reset value wrong");
  // Unimplemented severity bits hold their reset value
  sev_ro_a: assert property ((unc_sev_q & ~UNC_IMPL) == (SEV_RST & ~UNC_IMPL)) // R04
    else $error("read-only severity bit changed");
  // Detected correctable error is flagged next cycle
  cor_set_a: assert property (cor_new != WORD_ZERO // R05
    |=> (cor_sts_q & $past(cor_new)) == $past(cor_new))
    else $error("correctable status not set");
  // Write one clears when no event collides
  cor_clear_a: assert property ((bus_wr && wb_i.adr == OFF_COR_STS // R06
    && cor_new == WORD_ZERO) |=> (cor_sts_q & $past(wbits)) == WORD_ZERO)
    else $error("correctable status not cleared");
  // Fully masked correctable error stays silent
  cor_masked_a: assert property ((cor_new != WORD_ZERO // R07
    && cor_rep == WORD_ZERO) |=> !err_cor_o)
    else $error("masked correctable error reported");
  // Mask stays within implemented bits
  cor_msk_ro_a: assert property ((cor_msk_q & ~COR_IMPL) == WORD_ZERO) // R08
    else $error("read-only mask bit set");
  // Prefix flag only rises with a captured prefix
  plp_rise_a: assert property ($rose(plp_q) |-> $past(prefix_valid_i)) // R09
    else $error("prefix flag set without prefix");
  // Enables never set without the capability
  enable_cap_a: assert property ((mhen_q |-> MHR_CAPABLE) // R10 R12 R14
    and (cce_q |-> CRC_CHK_CAPABLE) and (cge_q |-> CRC_GEN_CAPABLE))
    else $error("enable set without capability");
  // Control read shows capabilities and zero reserved bits
  ctl_read_a: assert property ((bus_rd && wb_i.adr == OFF_CTL) // R11 R13 R15 R19
    |=> wb_ack_o && wb_dat_o[31:12] == 20'h0_0000 && wb_dat_o[CTL_MHCP] == MHR_CAPABLE
    && wb_dat_o[CTL_CCC] == CRC_CHK_CAPABLE && wb_dat_o[CTL_CGC] == CRC_GEN_CAPABLE)
    else $error("control read wrong");
  // Pointer takes the lowest new unmasked error
  ptr_load_a: assert property ((ptr_free && unc_rep != WORD_ZERO) // R16
    |=> (($past(unc_rep) >> ptr_q) & 32'h0000_0001) != WORD_ZERO
    && ($past(unc_rep) & ((32'h0000_0001 << ptr_q) - 32'h0000_0001)) == WORD_ZERO)
    else $error("first error pointer wrong");
  // Masked uncorrectable error neither moves pointer nor reports
  unc_masked_a: assert property ((unc_new != WORD_ZERO // R17
    && unc_rep == WORD_ZERO) |=> $stable(ptr_q) && !err_fatal_o && !err_nonfatal_o)
    else $error("masked uncorrectable error reported");
  // Uncorrectable detection sets status
  unc_set_a: assert property (unc_new != WORD_ZERO // R18
    |=> (unc_sts_q & $past(unc_new)) == $past(unc_new))
    else $error("uncorrectable status not set");
  // Zero write to status changes nothing
  zero_w1c_a: assert property ((bus_wr && wb_i.adr == OFF_UNC_STS // R19
    && wbits == WORD_ZERO && unc_new == WORD_ZERO) |=> $stable(unc_sts_q))
    else $error("zero write changed status");
  // Bus answers one cycle later, for one cycle
  bus_ack_a: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge timing wrong");
  // Read data is zero outside the acknowledge cycle
  rd_idle_a: assert property (!wb_ack_o |-> wb_dat_o == WORD_ZERO)
    else $error("read data outside acknowledge");
  // Interrupt level tracks unmasked status bits
  irq_level_a: assert property (irq_o == |(irq_sts_q & irq_msk_q))
    else $error("interrupt level wrong");
  // Unmasked correctable error is reported
  cor_report_a: assert property (cor_rep != WORD_ZERO |=> err_cor_o) // R07
    else $error("correctable report missing");

  // ==========================================================
  // Main scenarios reached
  fatal_seen_c: cover property (err_fatal_o);
  nf_seen_c:    cover property (err_nonfatal_o);
  cor_seen_c:   cover property (err_cor_o ##[1:20] irq_o);
  ptr_move_c:   cover property ($changed(ptr_q));
  w1c_c:        cover property (bus_wr && wb_i.adr == OFF_COR_STS && cor_sts_q != WORD_ZERO);

endmodule

// File: sim/aer_host_model.sv
// Host model: software reaching the error report registers over classic Wishbone.
// Assumes a slave on clk_i that acks one cycle after it takes a request.
module aer_host_model
  import aer_pkg::*;
(
  input  wire logic            clk_i,    // Bus clock
  input  wire logic [31:0]     wb_dat_i, // Read data from the bank
  input  wire logic            wb_ack_i, // Acknowledge from the bank
  output aer_pkg::aer_wb_req_t wb_o      // Request to the bank
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Bus cycles
  initial wb_o = '0;  // Idle bus at time zero

  // One classic cycle, held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    wb_o <= '{1'b1, 1'b1, w, a, 4'hF, d};
    // Wait as long as the slave takes; the bench watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (wb_ack_i !== 1'b1);
    q = wb_dat_i;  // Read data stands with ack
    wb_o <= '{1'b0, 1'b0, ~w, ~a, 4'h0, ~d};  // Released lines do not keep old values
  endtask
endmodule

// File: sim/aer_regs_tb.sv
// Self-checking bench for the error report register bank.
// Assumes the host model for bus cycles and a 10 MHz clock.
module aer_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import aer_pkg::*;

  // ==========================================================
  // Signals
  logic        clk_i          = 1'b0;  // Clock
  logic        rst_i          = 1'b1;  // Cold reset
  logic        hot_rst_i      = 1'b0;  // Hot reset
  logic        flr_i          = 1'b0;  // Function level reset
  logic        prefix_valid_i = 1'b0;  // Prefix captured
  logic [31:0] unc_err_i      = '0;    // Uncorrectable pulses
  logic [15:0] cor_err_i      = '0;    // Correctable pulses
  aer_wb_req_t wb_i;                   // Request from host
  logic [31:0] wb_dat_o;               // Read data
  logic        wb_ack_o, err_fatal_o, err_nonfatal_o, err_cor_o;
  logic        crc_chk_en_o, crc_gen_en_o, multi_hdr_en_o, irq_o;
  logic [31:0] rq;                     // Last bus word
  int          err_total      = 0;     // Mismatches
  int          checks_done    = 0;     // Comparisons

  always #50 clk_i = ~clk_i;  // 100 ns period

  aer_regs dut (
    .clk_i(clk_i), .rst_i(rst_i), .hot_rst_i(hot_rst_i), .flr_i(flr_i), .wb_i(wb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .unc_err_i(unc_err_i), .cor_err_i(cor_err_i),
    .prefix_valid_i(prefix_valid_i), .err_fatal_o(err_fatal_o),
    .err_nonfatal_o(err_nonfatal_o), .err_cor_o(err_cor_o), .crc_chk_en_o(crc_chk_en_o),
    .crc_gen_en_o(crc_gen_en_o), .multi_hdr_en_o(multi_hdr_en_o), .irq_o(irq_o)
  );
  aer_host_model host (.clk_i(clk_i), .wb_dat_i(wb_dat_o), .wb_ack_i(wb_ack_o), .wb_o(wb_i));

  // ==========================================================
  // Shared tasks
  // Compare one word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, '0, rq);
    chk(rq, exp, "read data");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rq);
  endtask
  // One-cycle error pulses
  task automatic pulse(input logic [31:0] u, input logic [15:0] c);
    @(posedge clk_i);
    unc_err_i <= u;
    cor_err_i <= c;
    @(posedge clk_i);
    unc_err_i <= '0;
    cor_err_i <= '0;
  endtask
  // Outputs: irq, fatal, nonfatal, corr, check, gen, multi
  task automatic outs(input logic [6:0] e);
    @(negedge clk_i);
    chk({25'h0, irq_o, err_fatal_o, err_nonfatal_o, err_cor_o, crc_chk_en_o, crc_gen_en_o,
         multi_hdr_en_o}, {25'h0, e}, "outputs");
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    outs(7'h00);
    rd(OFF_UNC_SEV, 32'h0046_2010);
    rd(OFF_COR_STS, 32'h0000_0000);
    rd(OFF_COR_MSK, 32'h0000_0000);
    rd(OFF_CTL, 32'h0000_00A0);
    rd(8'h40, 32'h0000_0000);
  endtask
  task automatic t_sev();
    wr(OFF_UNC_SEV, 32'hFFFF_FFFF);
    rd(OFF_UNC_SEV, 32'h005F_7010);
    wr(OFF_UNC_SEV, 32'h0004_0000);
    rd(OFF_UNC_SEV, 32'h0004_0000);
  endtask
  task automatic t_unc();
    pulse(32'h0040_0000, 16'h0000);
    outs(7'h00);
    rd(OFF_CTL, 32'h0000_00A0);
    prefix_valid_i <= 1'b1;
    pulse(32'h0004_0000, 16'h0000);
    outs(7'h20);
    pulse(32'h0010_0000, 16'h0000);
    outs(7'h10);
    rd(OFF_CTL, 32'h0000_08B2);
    rd(OFF_UNC_STS, 32'h0054_0000);
    wr(OFF_UNC_STS, 32'h0004_0000);
    rd(OFF_UNC_STS, 32'h0050_0000);
  endtask
  task automatic t_cor();
    pulse(32'h0000_0000, 16'hFFFF);
    outs(7'h08);
    rd(OFF_COR_STS, 32'h0000_71C1);
    wr(OFF_COR_STS, 32'h0000_0000);
    rd(OFF_COR_STS, 32'h0000_71C1);
    wr(OFF_COR_STS, 32'h0000_0080);
    rd(OFF_COR_STS, 32'h0000_7141);
    wr(OFF_COR_STS, 32'hFFFF_FFFF);
    rd(OFF_COR_STS, 32'h0000_0000);
    wr(OFF_COR_MSK, 32'hFFFF_FFFF);
    rd(OFF_COR_MSK, 32'h0000_71C1);
    pulse(32'h0000_0000, 16'h0001);
    outs(7'h00);
    rd(OFF_COR_STS, 32'h0000_0001);
  endtask
  task automatic t_ctl();
    wr(OFF_CTL, 32'hFFFF_FFFF);
    rd(OFF_CTL, 32'h0000_09F2);
    outs(7'h06);
  endtask
  // Interrupt raised, cleared by read, then masked
  task automatic t_irq();
    rd(OFF_IRQ_STS, 32'h0000_0007);
    wr(OFF_IRQ_MSK, 32'h0000_0007);
    wr(OFF_COR_MSK, 32'h0000_0000);
    pulse(32'h0000_0000, 16'h0040);
    outs(7'h4E);
    rd(OFF_IRQ_STS, 32'h0000_0001);
    outs(7'h06);
    wr(OFF_IRQ_MSK, 32'h0000_0000);
    pulse(32'h0000_0000, 16'h0040);
    outs(7'h0E);
    rd(OFF_IRQ_STS, 32'h0000_0001);
  endtask
  // Warm resets keep sticky state, cold reset restores it
  task automatic t_warm();
    wr(OFF_IRQ_MSK, 32'h0000_0007);
    @(posedge clk_i);
    hot_rst_i <= 1'b1;
    @(posedge clk_i);
    hot_rst_i <= 1'b0;
    flr_i     <= 1'b1;
    @(posedge clk_i);
    flr_i     <= 1'b0;
    rd(OFF_IRQ_MSK, 32'h0000_0000);
    rd(OFF_UNC_SEV, 32'h0004_0000);
    rd(OFF_COR_STS, 32'h0000_0041);
    rd(OFF_UNC_MSK, 32'h0040_0000);
    rd(OFF_CTL, 32'h0000_09F2);
    rd(OFF_UNC_STS, 32'h0050_0000);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFF_CTL, 32'h0000_00A0);
    rd(OFF_UNC_SEV, 32'h0046_2010);
    rd(OFF_COR_STS, 32'h0000_0000);
  endtask

  // ==========================================================
  // Verdict, main sequence and watchdog
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_sev();
    t_unc();
    t_cor();
    t_ctl();
    t_irq();
    t_warm();
    report_and_stop();
  end
  // Run needs about 160 cycles; cut off well beyond
  initial begin
    repeat (4000) @(posedge clk_i);
    err_total++;
    report_and_stop();
  end
endmodule
